//--- common/aabs_pkg.sv
// Constants, opcodes and register map of the accumulator execution datapath
package aabs_pkg;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int BIDX_W = 3;
	localparam int NIBBLE_W = 4;
	localparam int WB_ADR_W = 4;
	localparam int WB_DAT_W = 32;
	// Bus register offsets (byte addresses)
	localparam logic [WB_ADR_W-1:0] OFS_ACC = 4'h0;
	localparam logic [WB_ADR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [WB_ADR_W-1:0] OFS_CTRL = 4'h8;
	localparam logic [WB_ADR_W-1:0] OFS_STATE = 4'hC;
	// Field positions
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_NIBBLE = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_W = 3;
	localparam int CTRL_PRESC = 0;
	localparam int STATE_BUSY = 0;
	localparam int STATE_DROP = 1;
	localparam int STATE_W = 2;
	// Reset values
	localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;
	localparam logic CTRL_PRESC_RST = 1'b0;
	// Default file addresses of the I/O port and the timer counter
	localparam logic [FADDR_W-1:0] PORT_ADDR_DEF = 7'h05;
	localparam logic [FADDR_W-1:0] TIMER_ADDR_DEF = 7'h01;
	typedef enum logic [2:0] {
		add_immediate_op,
		add_register_op,
		and_immediate_op,
		and_register_op,
		bit_clear_op,
		bit_set_op,
		skip_if_bit_zero_op,
		skip_if_bit_one_op
	} aabs_op_t;
	typedef enum logic {ST_READY, ST_EXEC} aabs_state_t;
endpackage

//--- common/aabs_mem_if.sv
// Connection between the datapath and its file register memory
`timescale 1ns/1ps
`default_nettype none
interface aabs_mem_if #(parameter int AW = 7, parameter int DW = 8);
	logic ce;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] rd_data;
	logic wr_en;
	logic [AW-1:0] wr_addr;
	logic [DW-1:0] wr_data;
	modport ctrl(output ce, output rd_addr, output wr_en, output wr_addr, output wr_data,
		input rd_data);
	modport mem(input ce, input rd_addr, input wr_en, input wr_addr, input wr_data,
		output rd_data);
endinterface
`default_nettype wire

//--- design/aabs_file_mem.sv
// File register memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module aabs_file_mem #(parameter int AW = 7, parameter int DW = 8) (
	input wire logic clk,
	input wire logic rst_b,
	aabs_mem_if.mem bus
);
	logic [DW-1:0] store [2**AW];
	logic [DW-1:0] rd_reg;

	always_ff @(posedge clk) begin
		if (bus.ce && bus.wr_en) begin
			store[bus.wr_addr] <= bus.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_reg <= '0;
		end else if (bus.ce) begin
			rd_reg <= store[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_reg;
endmodule
`default_nettype wire

//--- design/aabs_exec.sv
// Accumulator ALU, bit and skip execution datapath with Wishbone register access
//
// Behaviour
// RL1 - Add immediate: accumulator plus 8-bit literal into accumulator, update carry, nibble, zero.
// RL2 - Add register: accumulator plus addressed file register, update carry, nibble, zero.
// RL3 - Register ops: destination 0 writes accumulator, destination 1 writes file register.
// RL4 - AND immediate: accumulator AND literal into accumulator, only zero flag changes.
// RL5 - AND register: accumulator AND file register to destination, only zero flag changes.
// RL6 - Bit clear: selected bit of file register forced low, flags untouched.
// RL7 - Bit set: selected bit of file register forced high, flags untouched.
// RL8 - Skip if zero: bit low discards next instruction, replaced by idle cycle.
// RL9 - Skip if one: bit high discards next instruction, flags unchanged.
// RL10 - Port register read-modify-write uses pin levels, not the output latch.
// RL11 - Writing the timer counter clears prescaler when prescaler belongs to timer.
// RL12 - Carry from bit 7, nibble carry from bit 3, zero when result zero.
// RL13 - One instruction cycle each; a skip adds exactly one idle cycle.
`timescale 1ns/1ps
`default_nettype none
module aabs_exec import aabs_pkg::*; #(
	parameter logic [FADDR_W-1:0] PORT_ADDR = PORT_ADDR_DEF,
	parameter logic [FADDR_W-1:0] TIMER_ADDR = TIMER_ADDR_DEF
) (
	input wire logic CORE_CLK,
	input wire logic RST_B,
	input wire logic CORE_CE,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [WB_ADR_W-1:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [WB_DAT_W-1:0] WB_DAT_I,
	output logic [WB_DAT_W-1:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire logic INSTR_VALID,
	input wire logic [2:0] INSTR_OP,
	input wire logic [DATA_W-1:0] INSTR_LIT,
	input wire logic [FADDR_W-1:0] INSTR_FADDR,
	input wire logic [BIDX_W-1:0] INSTR_BIT,
	input wire logic INSTR_DEST,
	output logic INSTR_READY,
	output logic SKIP_IDLE,
	output logic PRESCALE_CLR,
	input wire logic [DATA_W-1:0] PORT_PINS,
	output logic [DATA_W-1:0] PORT_LATCH
);
	function automatic logic [DATA_W-1:0] bit_mask(input logic [BIDX_W-1:0] idx);
		bit_mask = DATA_W'(1) << idx;
	endfunction

	aabs_mem_if #(.AW(FADDR_W), .DW(DATA_W)) mem_bus ();
	aabs_file_mem #(.AW(FADDR_W), .DW(DATA_W)) u_mem (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.bus(mem_bus.mem)
	);

	aabs_state_t state_reg;
	aabs_op_t op_reg;
	logic [DATA_W-1:0] acc_reg, lit_reg, pins_meta_reg, pins_reg, result;
	logic [FADDR_W-1:0] fa_reg;
	logic [BIDX_W-1:0] bit_reg;
	logic [FLAG_W-1:0] flags_reg;
	logic dest_reg, drop_reg, skip_pend_reg, presc_own_reg;
	logic accept, live, wr_file, wr_acc, upd_all, upd_zero, skip_hit;
	logic [DATA_W-1:0] operand, b_val, mask;
	logic [DATA_W:0] sum9;
	logic [NIBBLE_W:0] nib;
	logic wb_req, wb_wr;

	assign accept = CORE_CE && INSTR_READY && INSTR_VALID;
	assign live = (state_reg == ST_EXEC) && !drop_reg;

	// Pins come from outside the clock domain
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pins_meta_reg <= '0;
			pins_reg <= '0;
		end else if (CORE_CE) begin
			pins_meta_reg <= PORT_PINS;
			pins_reg <= pins_meta_reg;
		end
	end

	// RL10 pin levels as source
	assign operand = (fa_reg == PORT_ADDR) ? pins_reg : mem_bus.rd_data;
	assign b_val = (op_reg == add_immediate_op || op_reg == and_immediate_op) ? lit_reg : operand;
	assign mask = bit_mask(bit_reg);
	// RL12 carry and nibble carry
	assign sum9 = {1'b0, acc_reg} + {1'b0, b_val};
	assign nib = {1'b0, acc_reg[NIBBLE_W-1:0]} + {1'b0, b_val[NIBBLE_W-1:0]};

	always_comb begin
		result = operand;
		wr_file = 1'b0;
		wr_acc = 1'b0;
		upd_all = 1'b0;
		upd_zero = 1'b0;
		skip_hit = 1'b0;
		unique case (op_reg)
			// RL1 add immediate
			add_immediate_op: begin
				result = sum9[DATA_W-1:0];
				wr_acc = 1'b1;
				upd_all = 1'b1;
			end
			// RL2 add register, RL3 destination
			add_register_op: begin
				result = sum9[DATA_W-1:0];
				wr_acc = !dest_reg;
				wr_file = dest_reg;
				upd_all = 1'b1;
			end
			// RL4 AND immediate
			and_immediate_op: begin
				result = acc_reg & b_val;
				wr_acc = 1'b1;
				upd_zero = 1'b1;
			end
			// RL5 AND register, RL3 destination
			and_register_op: begin
				result = acc_reg & b_val;
				wr_acc = !dest_reg;
				wr_file = dest_reg;
				upd_zero = 1'b1;
			end
			// RL6 bit clear
			bit_clear_op: begin
				result = operand & ~mask;
				wr_file = 1'b1;
			end
			// RL7 bit set
			bit_set_op: begin
				result = operand | mask;
				wr_file = 1'b1;
			end
			// RL8 skip when bit low
			skip_if_bit_zero_op: skip_hit = (operand & mask) == '0;
			// RL9 skip when bit high
			skip_if_bit_one_op: skip_hit = (operand & mask) != '0;
		endcase
	end

	assign mem_bus.ce = CORE_CE;
	assign mem_bus.rd_addr = INSTR_FADDR;
	assign mem_bus.wr_en = live && wr_file;
	assign mem_bus.wr_addr = fa_reg;
	assign mem_bus.wr_data = result;

	// RL13 two clocks per instruction cycle
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_READY;
			INSTR_READY <= 1'b0;
		end else if (CORE_CE) begin
			unique case (state_reg)
				ST_READY: begin
					INSTR_READY <= !accept;
					if (accept) begin
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_reg <= ST_READY;
					INSTR_READY <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			op_reg <= add_immediate_op;
			lit_reg <= '0;
			fa_reg <= '0;
			bit_reg <= '0;
			dest_reg <= 1'b0;
		end else if (CORE_CE && accept) begin
			op_reg <= aabs_op_t'(INSTR_OP);
			lit_reg <= INSTR_LIT;
			fa_reg <= INSTR_FADDR;
			bit_reg <= INSTR_BIT;
			dest_reg <= INSTR_DEST;
		end
	end

	// RL8 RL9 discarded instruction becomes an idle cycle
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			skip_pend_reg <= 1'b0;
			drop_reg <= 1'b0;
			SKIP_IDLE <= 1'b0;
		end else if (CORE_CE) begin
			if (accept) begin
				drop_reg <= skip_pend_reg;
				SKIP_IDLE <= skip_pend_reg;
				skip_pend_reg <= 1'b0;
			end else if (state_reg == ST_EXEC) begin
				SKIP_IDLE <= 1'b0;
				if (live) begin
					skip_pend_reg <= skip_hit;
				end
			end
		end
	end

	// Bus writes lose to a same-cycle instruction update
	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wb_wr = CORE_CE && wb_req && WB_WE_I && WB_SEL_I[0];

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			acc_reg <= ACC_RST;
		end else if (CORE_CE) begin
			if (live && wr_acc) begin
				acc_reg <= result;
			end else if (wb_wr && WB_ADR_I == OFS_ACC) begin
				acc_reg <= WB_DAT_I[DATA_W-1:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			flags_reg <= FLAGS_RST;
		end else if (CORE_CE) begin
			// RL12 flag update
			if (live && upd_all) begin
				flags_reg[FLAG_CARRY] <= sum9[DATA_W];
				flags_reg[FLAG_NIBBLE] <= nib[NIBBLE_W];
				flags_reg[FLAG_ZERO] <= result == '0;
			end else if (live && upd_zero) begin
				flags_reg[FLAG_ZERO] <= result == '0;
			end else if (wb_wr && WB_ADR_I == OFS_STATUS) begin
				flags_reg <= WB_DAT_I[FLAG_W-1:0];
			end
		end
	end

	// RL11 prescaler clear on timer write, port latch shadow
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			presc_own_reg <= CTRL_PRESC_RST;
			PRESCALE_CLR <= 1'b0;
			PORT_LATCH <= '0;
		end else if (CORE_CE) begin
			PRESCALE_CLR <= mem_bus.wr_en && fa_reg == TIMER_ADDR && presc_own_reg;
			if (mem_bus.wr_en && fa_reg == PORT_ADDR) begin
				PORT_LATCH <= result;
			end
			if (wb_wr && WB_ADR_I == OFS_CTRL) begin
				presc_own_reg <= WB_DAT_I[CTRL_PRESC];
			end
		end
	end

	// Single-cycle answer; unmapped offsets read zero
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else if (CORE_CE) begin
			WB_ACK_O <= wb_req;
			WB_DAT_O <= '0;
			if (wb_req && !WB_WE_I) begin
				unique case (WB_ADR_I)
					OFS_ACC: WB_DAT_O <= WB_DAT_W'(acc_reg);
					OFS_STATUS: WB_DAT_O <= WB_DAT_W'(flags_reg);
					OFS_CTRL: WB_DAT_O <= WB_DAT_W'(presc_own_reg);
					OFS_STATE: WB_DAT_O <= WB_DAT_W'({skip_pend_reg, state_reg == ST_EXEC});
					default: WB_DAT_O <= '0;
				endcase
			end
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);

	add_immediate_acc_a: assert property (CORE_CE && live && op_reg == add_immediate_op |=> acc_reg == DATA_W'($past(acc_reg) + $past(lit_reg))) else $error("add immediate sum wrong"); // RL1
	add_register_carry_a: assert property (CORE_CE && live && op_reg == add_register_op |=> flags_reg[FLAG_CARRY] == ($past(acc_reg) + $past(operand) > 2**DATA_W - 1)) else $error("add carry wrong"); // RL2
	dest_file_a: assert property (CORE_CE && live && (op_reg == add_register_op || op_reg == and_register_op) && dest_reg |-> mem_bus.wr_en ##1 $stable(acc_reg)) else $error("destination one misrouted"); // RL3
	and_flags_a: assert property (CORE_CE && live && op_reg == and_immediate_op |=> acc_reg == ($past(acc_reg) & $past(lit_reg)) && flags_reg[FLAG_CARRY] == $past(flags_reg[FLAG_CARRY])) else $error("AND immediate wrong"); // RL4
	and_register_a: assert property (CORE_CE && live && op_reg == and_register_op |=> $past(flags_reg[FLAG_NIBBLE]) == flags_reg[FLAG_NIBBLE]) else $error("AND register touched nibble flag"); // RL5
	bit_clear_a: assert property (live && op_reg == bit_clear_op |-> mem_bus.wr_en && mem_bus.wr_data[bit_reg] == 1'b0) else $error("bit clear failed"); // RL6
	bit_set_a: assert property (CORE_CE && live && op_reg == bit_set_op |-> mem_bus.wr_data[bit_reg] ##1 $stable(flags_reg)) else $error("bit set failed"); // RL7
	skip_zero_a: assert property (CORE_CE && live && op_reg == skip_if_bit_zero_op && operand[bit_reg] == 1'b0 |=> skip_pend_reg) else $error("skip on zero missed"); // RL8
	skip_one_a: assert property (CORE_CE && live && op_reg == skip_if_bit_one_op |=> skip_pend_reg == $past(operand[bit_reg])) else $error("skip on one wrong"); // RL9
	port_source_a: assert property (CORE_CE && live && fa_reg == PORT_ADDR && op_reg == bit_set_op |=> PORT_LATCH == ($past(pins_reg) | (DATA_W'(1) << $past(bit_reg)))) else $error("port source not pins"); // RL10
	prescale_clear_a: assert property (CORE_CE && live && fa_reg == TIMER_ADDR && presc_own_reg && (op_reg inside {bit_clear_op, bit_set_op} || dest_reg && op_reg inside {add_register_op, and_register_op}) |=> PRESCALE_CLR) else $error("prescaler not cleared"); // RL11
	zero_flag_a: assert property (CORE_CE && live && (upd_all || upd_zero) |=> flags_reg[FLAG_ZERO] == ($past(result) == '0)) else $error("zero flag wrong"); // RL12
	idle_cycle_a: assert property (CORE_CE && state_reg == ST_EXEC && drop_reg |-> !mem_bus.wr_en ##1 $stable(acc_reg) && $stable(flags_reg)) else $error("idle cycle changed state"); // RL13
endmodule
`default_nettype wire

//--- tb/aabs_seq_model.sv
// Instruction issuer standing in for the core decoder and sequencer
`timescale 1ns/1ps
`default_nettype none
module aabs_seq_model import aabs_pkg::*; (
	input wire logic clk,
	input wire logic ready,
	output logic valid,
	output logic [2:0] op,
	output logic [DATA_W-1:0] lit,
	output logic [FADDR_W-1:0] faddr,
	output logic [BIDX_W-1:0] bidx,
	output logic dest,
	output logic hung
);
	initial begin
		valid = 1'h0;
		op = 3'h0;
		lit = 8'h00;
		faddr = 7'h00;
		bidx = 3'h0;
		dest = 1'h0;
		hung = 1'h0;
	end

	// Fields except op are scrambled once taken, so a late read of them shows up
	task automatic go(input aabs_op_t o, input logic [7:0] l, input logic [6:0] f,
		input logic [2:0] b, input logic d);
		int n;
		@(posedge clk);
		valid <= 1'h1;
		op <= o;
		lit <= l;
		faddr <= f;
		bidx <= b;
		dest <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'h1 && n < 40);
		hung <= (n >= 40);
		valid <= 1'h0;
		lit <= ~l;
		faddr <= ~f;
		bidx <= ~b;
		dest <= ~d;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_accum_alu_bit_skip_exec.sv
// Self-checking bench for the accumulator execution datapath
`timescale 1ns/1ps
`default_nettype none
module tb_accum_alu_bit_skip_exec import aabs_pkg::*;;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic [7:0] pins = 8'h00, latch, lit;
	logic ack, ready, skip_idle, pclr, valid, dest, hung;
	logic [2:0] op, bidx;
	logic [6:0] faddr;
	int miscompares = 0, tests_run = 0, skip_cnt = 0, pclr_cnt = 0;
	localparam logic [6:0] FR = 7'h7F;

	initial begin
		forever #25 clk = ~clk;
	end

	aabs_exec i_dut (.CORE_CLK(clk), .RST_B(rst_b), .CORE_CE(1'h1), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .INSTR_VALID(valid), .INSTR_OP(op),
		.INSTR_LIT(lit), .INSTR_FADDR(faddr), .INSTR_BIT(bidx), .INSTR_DEST(dest),
		.INSTR_READY(ready), .SKIP_IDLE(skip_idle), .PRESCALE_CLR(pclr),
		.PORT_PINS(pins), .PORT_LATCH(latch));
	aabs_seq_model i_seq (.clk(clk), .ready(ready), .valid(valid), .op(op), .lit(lit),
		.faddr(faddr), .bidx(bidx), .dest(dest), .hung(hung));

	always @(posedge clk) begin
		if (skip_idle === 1'h1)
			skip_cnt++;
		if (pclr === 1'h1)
			pclr_cnt++;
	end
	always @(posedge hung) begin
		miscompares++;
		end_sim();
	end

	task automatic end_sim;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic cycle: request held until ack is sampled, then released
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		if (n >= 20) begin
			miscompares++;
			end_sim();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		logic [31:0] q;
		wb(1'h1, a, d, q);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 8'h00, q);
		chk(q, e);
	endtask

	task automatic t_reset;
		rd(OFS_ACC, ACC_RST);
		rd(OFS_STATUS, FLAGS_RST);
		rd(OFS_CTRL, CTRL_PRESC_RST);
		rd(4'h2, 32'h0);
		rd(OFS_STATE, 32'h0);
	endtask

	task automatic t_imm;
		wr(OFS_ACC, 8'hF8);
		i_seq.go(add_immediate_op, 8'h08, 7'h00, 3'h0, 1'h0);
		rd(OFS_ACC, 32'h00);
		rd(OFS_STATUS, 32'h7);
		i_seq.go(add_immediate_op, 8'h02, 7'h00, 3'h0, 1'h0);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_STATUS, 8'h03);
		wr(OFS_ACC, 8'hF0);
		i_seq.go(and_immediate_op, 8'h0F, 7'h00, 3'h0, 1'h0);
		rd(OFS_ACC, 32'h00);
		rd(OFS_STATUS, 32'h7);
	endtask

	// Top file address; contents set through the datapath itself
	task automatic t_reg;
		wr(OFS_ACC, 8'h00);
		i_seq.go(and_register_op, 8'h00, FR, 3'h0, 1'h1);
		wr(OFS_ACC, 8'h3C);
		i_seq.go(add_register_op, 8'h00, FR, 3'h0, 1'h1);
		rd(OFS_ACC, 32'h3C);
		wr(OFS_ACC, 8'h0C);
		i_seq.go(add_register_op, 8'h00, FR, 3'h0, 1'h0);
		rd(OFS_ACC, 32'h48);
		rd(OFS_STATUS, 32'h2);
		wr(OFS_STATUS, 8'h05);
		wr(OFS_ACC, 8'hFF);
		i_seq.go(and_register_op, 8'h00, FR, 3'h0, 1'h0);
		rd(OFS_ACC, 32'h3C);
		rd(OFS_STATUS, 32'h1);
	endtask

	task automatic t_bits;
		i_seq.go(bit_clear_op, 8'h00, FR, 3'h2, 1'h0);
		i_seq.go(bit_set_op, 8'h00, FR, 3'h7, 1'h0);
		rd(OFS_STATUS, 32'h1);
		wr(OFS_ACC, 8'hFF);
		i_seq.go(and_register_op, 8'h00, FR, 3'h0, 1'h0);
		rd(OFS_ACC, 32'hB8);
	endtask

	// File holds 8'hB8 here: bits 0 and 2 low, bits 3 and 7 high
	task automatic t_skip;
		aabs_op_t so[4] = '{skip_if_bit_zero_op, skip_if_bit_zero_op,
			skip_if_bit_one_op, skip_if_bit_one_op};
		logic [2:0] sb[4] = '{3'h0, 3'h3, 3'h7, 3'h2};
		logic sd[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
		for (int i = 0; i < 4; i++) begin
			wr(OFS_ACC, 8'h10);
			skip_cnt = 0;
			i_seq.go(so[i], 8'h00, FR, sb[i], 1'h0);
			rd(OFS_STATE, {30'h0, sd[i], 1'h0});
			i_seq.go(add_immediate_op, 8'h01, 7'h00, 3'h0, 1'h0);
			i_seq.go(add_immediate_op, 8'h02, 7'h00, 3'h0, 1'h0);
			rd(OFS_ACC, sd[i] ? 32'h12 : 32'h13);
			chk(skip_cnt, {31'h0, sd[i]});
		end
	endtask

	task automatic t_port;
		i_seq.go(bit_set_op, 8'h00, PORT_ADDR_DEF, 3'h0, 1'h0);
		repeat (3) @(posedge clk);
		chk(latch, 32'h5B);
		pins <= 8'hA5;
		repeat (4) @(posedge clk);
		i_seq.go(bit_clear_op, 8'h00, PORT_ADDR_DEF, 3'h0, 1'h0);
		repeat (3) @(posedge clk);
		chk(latch, 32'hA4);
	endtask

	// A zero accumulator lets the first AND turn the unwritten timer word into a known one
	task automatic t_timer(input logic [7:0] own, input aabs_op_t o, input logic d, input int e);
		wr(OFS_CTRL, own);
		wr(OFS_ACC, 8'h00);
		pclr_cnt = 0;
		i_seq.go(o, 8'h00, TIMER_ADDR_DEF, 3'h0, d);
		repeat (4) @(posedge clk);
		chk(pclr_cnt, e);
	endtask

	initial begin
		pins <= 8'h5A;
		repeat (12) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		t_reset();
		t_imm();
		t_reg();
		t_bits();
		t_skip();
		t_port();
		t_timer(8'h01, and_register_op, 1'h1, 1);
		t_timer(8'h01, bit_set_op, 1'h0, 1);
		t_timer(8'h00, bit_set_op, 1'h0, 0);
		t_timer(8'h01, add_register_op, 1'h0, 0);
		end_sim();
	end
endmodule
`default_nettype wire
